// file: peripheral_register_port.sv
//Function
//- 8-bit read keeps upper buffer nibbles
//- Invalid read bits give zero, fixed per register
//- Only power-on reset clears; others hold
//- Bits 7..4 hold horizontal start
//- Bits 3..0 hold vertical start
//- ADC reference stores four bits, upper zero
//- Code zero selects zero-volt reference
//- Display start answers at address 01H
//- Write-only reads undefined; read-only writes ignored
//- Each transfer completes in one cycle
//- Writes ignore upper nibbles, invalid bits
`timescale 1ns/1ps
`default_nettype none
module peripheral_register_port
	import periph_pkg::*;
(
	input  wire logic                         i_clk,
	input  wire logic                         i_resetn,
	input  wire logic                         i_clkstop_reset,
	input  wire logic                         i_ce_reset,
	input  wire logic                         i_read_instr,
	input  wire logic                         i_write_instr,
	input  wire logic [periph_pkg::PADDR_W-1:0] i_paddr,
	input  wire logic [15:0]                  i_buffer_load,
	input  wire logic                         i_buffer_load_en,
	output logic [15:0]                       o_buffer,
	output logic [3:0]                        o_hstart,
	output logic [3:0]                        o_vstart,
	output logic [3:0]                        o_adc_code,
	output logic                              o_adc_zero_ref,
	output logic [4:0]                        o_adc_half_steps,
	output logic                              o_xfer_done
);
	import periph_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0]  disp_start_r;
	logic [3:0]  adc_ref_r;
	logic [15:0] buffer_r;
	logic        done_r;
	logic        zero_r;
	logic [4:0]  steps_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic sel_disp = (i_paddr == ADDR_DISP_START);
	wire logic sel_adc  = (i_paddr == ADDR_ADC_REF);
	// Writes to unmapped/read-only addresses hit no register
	wire logic wr_disp  = i_write_instr & sel_disp;
	wire logic wr_adc   = i_write_instr & sel_adc;
	wire logic [7:0] wr_byte = buffer_r[7:0];
	wire logic [7:0] disp_nxt = wr_byte & DISP_START_MASK;
	wire logic [3:0] adc_nxt =
		wr_byte[ADC_CODE_W-1:0];

	// Invalid bits read as zero for both registers
	wire logic [7:0] rd_byte =
		sel_disp ? disp_start_r :
		sel_adc  ? ({4'h0, adc_ref_r} & ADC_REF_MASK) :
		UNDEF_READ;
	wire logic [15:0] buffer_nxt =
		i_read_instr ? {buffer_r[15:8], rd_byte} :
		i_buffer_load_en ? i_buffer_load : buffer_r;

	// Decode the value the code register takes at this edge, so the
	// level outputs change together with the code, not a clock later
	wire logic       zero_nxt;
	wire logic [4:0] steps_nxt;
	wire logic [3:0] adc_nxt_sel;
	assign adc_nxt_sel = wr_adc ? adc_nxt : adc_ref_r;
	adc_ref_decoder u_dec (
		.i_code       (adc_nxt_sel),
		.o_zero_ref   (zero_nxt),
		.o_half_steps (steps_nxt)
	);

	// ------------------------------------------------------------
	// Registers; only power-on reset clears them, the clock-stop
	// and CE resets are deliberately not wired into any flop
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			disp_start_r <= DISP_START_POR;
			adc_ref_r    <= ADC_REF_POR;
		end else begin
			if (wr_disp)
				disp_start_r <= disp_nxt;
			if (wr_adc)
				adc_ref_r <= adc_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			buffer_r <= BUFFER_POR;
			done_r   <= 1'b0;
			zero_r   <= 1'b1;
			steps_r  <= 5'h00;
		end else begin
			buffer_r <= buffer_nxt;
			done_r   <= i_read_instr | i_write_instr;
			zero_r   <= zero_nxt;
			steps_r  <= steps_nxt;
		end
	end

	assign o_buffer         = buffer_r;
	assign o_hstart         = disp_start_r[HSTART_MSB:HSTART_LSB];
	assign o_vstart         = disp_start_r[VSTART_MSB:VSTART_LSB];
	assign o_adc_code       = adc_ref_r;
	assign o_adc_zero_ref   = zero_r;
	assign o_adc_half_steps = steps_r;
	assign o_xfer_done      = done_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_upper_kept;
		@(posedge i_clk) disable iff (!i_resetn)
		i_read_instr |=> o_buffer[15:8] == $past(buffer_r[15:8]);
	endproperty
	a_upper_kept: assert property (p_upper_kept)
		else $error("upper buffer byte changed on read");

	property p_adc_read_zero;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read_instr && sel_adc) |=> o_buffer[7:4] == 4'h0;
	endproperty
	a_adc_read_zero: assert property (p_adc_read_zero)
		else $error("adc reference upper bits not zero");

	property p_hold_other_reset;
		@(posedge i_clk) disable iff (!i_resetn)
		(!i_write_instr && (i_clkstop_reset || i_ce_reset))
		|=> $stable(disp_start_r) && $stable(adc_ref_r);
	endproperty
	a_hold_other_reset: assert property (p_hold_other_reset)
		else $error("register changed on clock-stop or ce reset");

	property p_hstart;
		@(posedge i_clk) disable iff (!i_resetn)
		wr_disp |=> o_hstart == $past(buffer_r[7:4]);
	endproperty
	a_hstart: assert property (p_hstart)
		else $error("horizontal start not loaded");

	property p_vstart;
		@(posedge i_clk) disable iff (!i_resetn)
		wr_disp |=> o_vstart == $past(buffer_r[3:0]);
	endproperty
	a_vstart: assert property (p_vstart)
		else $error("vertical start not loaded");

	property p_adc_store;
		@(posedge i_clk) disable iff (!i_resetn)
		wr_adc |=> o_adc_code == $past(buffer_r[3:0]);
	endproperty
	a_adc_store: assert property (p_adc_store)
		else $error("adc code not stored");

	property p_zero_ref;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 (o_adc_zero_ref == (o_adc_code == 4'h0));
	endproperty
	a_zero_ref: assert property (p_zero_ref)
		else $error("zero reference mismatch");

	property p_disp_read;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read_instr && sel_disp) |=> o_buffer[7:0] == $past(disp_start_r);
	endproperty
	a_disp_read: assert property (p_disp_read)
		else $error("display start read wrong");

	property p_done;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read_instr || i_write_instr) |=> o_xfer_done;
	endproperty
	a_done: assert property (p_done)
		else $error("transfer not done in one cycle");

	property p_strobe;
		@(posedge i_clk) disable iff (!i_resetn)
		!wr_disp |=> $stable(disp_start_r);
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("display start written without strobe");

	property p_done_pulse;
		@(posedge i_clk) disable iff (!i_resetn)
		!(i_read_instr || i_write_instr) |=> !o_xfer_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("transfer done without instruction");

	property p_adc_strobe;
		@(posedge i_clk) disable iff (!i_resetn)
		!wr_adc |=> $stable(adc_ref_r);
	endproperty
	a_adc_strobe: assert property (p_adc_strobe)
		else $error("adc code written without strobe");

	property p_disp_addr_only;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_write_instr && !sel_disp) |=> $stable(disp_start_r);
	endproperty
	a_disp_addr_only: assert property (p_disp_addr_only)
		else $error("display start written at other address");

	property p_unmapped_read;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read_instr && !sel_disp && !sel_adc)
		|=> o_buffer[7:0] == UNDEF_READ;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read low byte wrong");

	property p_adc_read_code;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read_instr && sel_adc) |=> o_buffer[3:0] == $past(adc_ref_r);
	endproperty
	a_adc_read_code: assert property (p_adc_read_code)
		else $error("adc code read back wrong");
endmodule : peripheral_register_port
`default_nettype wire

// file: periph_pkg.sv
package periph_pkg;
	// ------------------------------------------------------------
	// Peripheral addresses and field layout
	// ------------------------------------------------------------
	localparam int          PADDR_W          = 7;
	localparam logic [6:0]  ADDR_DISP_START  = 7'h01;
	localparam logic [6:0]  ADDR_ADC_REF     = 7'h02;
	localparam int          HSTART_MSB       = 7;
	localparam int          HSTART_LSB       = 4;
	localparam int          VSTART_MSB       = 3;
	localparam int          VSTART_LSB       = 0;
	localparam int          ADC_CODE_W       = 4;
	localparam logic [7:0]  DISP_START_MASK  = 8'hFF;
	localparam logic [7:0]  ADC_REF_MASK     = 8'h0F;
	// Power-on content is undefined; these are the plain values we load
	localparam logic [7:0]  DISP_START_POR   = 8'h00;
	localparam logic [3:0]  ADC_REF_POR      = 4'h0;
	localparam logic [15:0] BUFFER_POR       = 16'h0000;
	// Value returned for unmapped or write-only reads
	localparam logic [7:0]  UNDEF_READ       = 8'h00;
	// Transfer completes in this many clocks after the instruction
	localparam int          XFER_CYCLES      = 1;
endpackage : periph_pkg

// file: adc_ref_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ref_decoder (
	input  wire logic [3:0] i_code,
	output logic            o_zero_ref,
	output logic [4:0]      o_half_steps
);
	// ------------------------------------------------------------
	// Reference level in half-LSB units: 0 for code 0, else 2x-1
	// ------------------------------------------------------------
	assign o_zero_ref   = (i_code == 4'h0);
	assign o_half_steps = o_zero_ref ? 5'h00
		: 5'({i_code, 1'b0} - 5'h01);
endmodule : adc_ref_decoder
`default_nettype wire

// file: core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        i_clk,
	output logic             o_rd,
	output logic             o_wr,
	output logic             o_ld_en,
	output logic [6:0]       o_addr,
	output logic [15:0]      o_ld
);
	initial begin
		o_rd = 1'h0;
		o_wr = 1'h0;
		o_ld_en = 1'h0;
		o_addr = 7'h7F;
		o_ld = 16'h0000;
	end
	// Released lines show the inverse so stale values never look valid
	task automatic load(input logic [15:0] v);
		@(posedge i_clk) #1;
		o_ld = v;
		o_ld_en = 1'h1;
		@(posedge i_clk) #1;
		o_ld_en = 1'h0;
		o_ld = ~v;
	endtask : load
	task automatic xfer(input logic wr, input logic [6:0] a);
		@(posedge i_clk) #1;
		o_addr = a;
		o_rd = !wr;
		o_wr = wr;
		@(posedge i_clk) #1;
		o_rd = 1'h0;
		o_wr = 1'h0;
		o_addr = ~a;
	endtask : xfer
endmodule : core_model
`default_nettype wire

// file: test_peripheral_register_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_register_port;
	import periph_pkg::*;
	logic        clk, resetn, cs_rst, ce_rst, rd, wr, ld_en, done, zref;
	logic [6:0]  addr;
	logic [15:0] ld, buffer;
	logic [3:0]  hs, vs, code;
	logic [4:0]  half;
	int          err_total = 0;
	int          compares = 0;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
	// ------------------------------------------------------------
	// Design, processor model and clock
	// ------------------------------------------------------------
	peripheral_register_port dut_u (.i_clk(clk), .i_resetn(resetn),
		.i_clkstop_reset(cs_rst), .i_ce_reset(ce_rst), .i_read_instr(rd),
		.i_write_instr(wr), .i_paddr(addr), .i_buffer_load(ld),
		.i_buffer_load_en(ld_en), .o_buffer(buffer), .o_hstart(hs),
		.o_vstart(vs), .o_adc_code(code), .o_adc_zero_ref(zref),
		.o_adc_half_steps(half), .o_xfer_done(done));
	core_model core_u (.i_clk(clk), .o_rd(rd), .o_wr(wr), .o_ld_en(ld_en),
		.o_addr(addr), .o_ld(ld));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic wrap_up;
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic after_reset;
		`CHK("hstart", 4'h0, hs)
		`CHK("zero_ref", 1'h1, zref)
		`CHK("buffer", 16'h0000, buffer)
	endtask : after_reset
	task automatic disp;
		core_u.load(16'hA5C3);
		`CHK("done", 1'h0, done)
		core_u.xfer(1'h1, ADDR_DISP_START);
		`CHK("done", 1'h1, done)
		`CHK("hstart", 4'hC, hs)
		`CHK("vstart", 4'h3, vs)
		core_u.load(16'hBEEF);
		core_u.xfer(1'h0, ADDR_DISP_START);
		`CHK("buffer", 16'hBEC3, buffer)
		`CHK("low byte", 8'hC3, buffer[7:0])
	endtask : disp
	task automatic adc;
		core_u.load(16'h12F7);
		core_u.xfer(1'h1, ADDR_ADC_REF);
		`CHK("code", 4'h7, code)
		`CHK("half", 5'h0D, half)
		`CHK("zero_ref", 1'h0, zref)
		core_u.load(16'hFFFF);
		core_u.xfer(1'h0, ADDR_ADC_REF);
		`CHK("buffer", 16'hFF07, buffer)
		core_u.load(16'h0050);
		core_u.xfer(1'h1, ADDR_ADC_REF);
		`CHK("zero_ref", 1'h1, zref)
		`CHK("half", 5'h00, half)
	endtask : adc
	// The reset levels stay as set until the next call changes them
	task automatic unmapped_hold(input logic cs, input logic ce);
		cs_rst = cs;
		ce_rst = ce;
		core_u.load(16'h0099);
		core_u.xfer(1'h1, 7'h03);
		`CHK("hstart", 4'hC, hs)
		core_u.xfer(1'h0, 7'h03);
		`CHK("buffer", 16'h0000, buffer)
		`CHK("vstart", 4'h3, vs)
		`CHK("code", 4'h0, code)
	endtask : unmapped_hold
	initial begin
		resetn = 1'h0;
		cs_rst = 1'h0;
		ce_rst = 1'h0;
		repeat (3) @(posedge clk);
		#1 resetn = 1'h1;
		after_reset();
		disp();
		adc();
		unmapped_hold(1'h1, 1'h0);
		unmapped_hold(1'h0, 1'h1);
		wrap_up();
	end
	initial begin
		#20000;
		err_total++;
		wrap_up();
	end
endmodule : test_peripheral_register_port
`default_nettype wire
